// [rtl/tmc_pkg.sv]
// ==========================================================
// register map, fields and reset values
package tmc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 16;

    // ==========================================================
    // offsets
    localparam logic [7:0] OFF_CTRL_A   = 8'h80;
    localparam logic [7:0] OFF_CTRL_B   = 8'h81;
    localparam logic [7:0] OFF_CTRL_C   = 8'h82;
    localparam logic [7:0] OFF_STATUS   = 8'h83;
    localparam logic [7:0] OFF_CNT_LO   = 8'h84;
    localparam logic [7:0] OFF_CNT_HI   = 8'h85;
    localparam logic [7:0] OFF_CAP_LO   = 8'h86;
    localparam logic [7:0] OFF_CAP_HI   = 8'h87;
    localparam logic [7:0] OFF_CMPA_LO  = 8'h88;
    localparam logic [7:0] OFF_CMPA_HI  = 8'h89;
    localparam logic [7:0] OFF_CMPB_LO  = 8'h8a;
    localparam logic [7:0] OFF_CMPB_HI  = 8'h8b;

    // ==========================================================
    // field positions
    localparam int A_COMA_LSB   = 6;
    localparam int A_COMB_LSB   = 4;
    localparam int A_WAVE_LSB   = 0;
    localparam int B_FILT_BIT   = 7;
    localparam int B_EDGE_BIT   = 6;
    localparam int B_WAVE_LSB   = 3;
    localparam int B_CSEL_LSB   = 0;
    localparam int C_FORCE_A    = 7;
    localparam int C_FORCE_B    = 6;
    localparam int S_OVF_BIT    = 0;
    localparam int S_MA_BIT     = 1;
    localparam int S_MB_BIT     = 2;
    localparam int S_CAP_BIT    = 5;

    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
    localparam logic [7:0] CTRL_B_WMASK = 8'hdf;

    // ==========================================================
    // tops, prescale, filter
    localparam logic [15:0] TOP_MAX  = 16'hffff;
    localparam logic [15:0] TOP_8B   = 16'h00ff;
    localparam logic [15:0] TOP_9B   = 16'h01ff;
    localparam logic [15:0] TOP_10B  = 16'h03ff;
    localparam int PRE_W     = 10;
    localparam logic [9:0] DIV8_M    = 10'h007;
    localparam logic [9:0] DIV64_M   = 10'h03f;
    localparam logic [9:0] DIV256_M  = 10'h0ff;
    localparam logic [9:0] DIV1024_M = 10'h3ff;
    localparam int FILTER_LEN = 4;

    typedef enum logic [2:0] {
        TMC_CS_STOP, TMC_CS_DIV1, TMC_CS_DIV8, TMC_CS_DIV64,
        TMC_CS_DIV256, TMC_CS_DIV1024, TMC_CS_EXT_FALL, TMC_CS_EXT_RISE
    } tmc_csel_t;

    typedef enum logic [1:0] {
        TMC_NONPWM, TMC_FAST, TMC_DUAL
    } tmc_class_t;

    typedef enum logic [1:0] {
        TMC_UPD_NOW, TMC_UPD_TOP, TMC_UPD_BOT
    } tmc_upd_t;
endpackage

// [rtl/tmc_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// timer tick: prescaler taps and external pin edge
module tmc_tick_gen
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic [2:0] clk_sel,
    // pin
    input  wire logic       ext_tick_pin,
    // tick enable
    output logic            timer_tick
);
    logic [PRE_W-1:0] pre_reg;
    logic             ext_s1_reg;
    logic             ext_s2_reg;
    logic             ext_s3_reg;
    wire              ext_rise = ext_s2_reg & ~ext_s3_reg;
    wire              ext_fall = ~ext_s2_reg & ext_s3_reg;
    tmc_csel_t        csel;

    assign csel = tmc_csel_t'(clk_sel);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_reg    <= '0;
            ext_s1_reg <= 1'b0;
            ext_s2_reg <= 1'b0;
            ext_s3_reg <= 1'b0;
        end else begin
            pre_reg    <= pre_reg + 1'b1;
            ext_s1_reg <= ext_tick_pin;
            ext_s2_reg <= ext_s1_reg;
            ext_s3_reg <= ext_s2_reg;
        end
    end

    always_comb begin
        unique case (csel)
            TMC_CS_STOP:     timer_tick = 1'b0;
            TMC_CS_DIV1:     timer_tick = 1'b1;
            TMC_CS_DIV8:     timer_tick = &(pre_reg | ~DIV8_M);
            TMC_CS_DIV64:    timer_tick = &(pre_reg | ~DIV64_M);
            TMC_CS_DIV256:   timer_tick = &(pre_reg | ~DIV256_M);
            TMC_CS_DIV1024:  timer_tick = &(pre_reg | ~DIV1024_M);
            TMC_CS_EXT_FALL: timer_tick = ext_fall;
            TMC_CS_EXT_RISE: timer_tick = ext_rise;
        endcase
    end
endmodule
`default_nettype wire

// [rtl/tmc_capture_filter.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// capture input: sync, optional filter, edge select
module tmc_capture_filter
    import tmc_pkg::*;
#(
    parameter int LEN = FILTER_LEN
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // control
    input  wire logic filter_en,
    input  wire logic edge_sel,
    // pin
    input  wire logic capture_pin,
    // event
    output logic      cap_event
);
    logic           s1_reg;
    logic [LEN-1:0] hist_reg;
    logic           filt_reg;
    logic           prev_reg;
    wire            all_one  = &hist_reg;
    wire            all_zero = ~|hist_reg;
    wire            level    = filter_en ? filt_reg : hist_reg[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg   <= 1'b0;
            hist_reg <= '0;
            filt_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            s1_reg   <= capture_pin;
            hist_reg <= {hist_reg[LEN-2:0], s1_reg};
            if (all_one || all_zero) begin
                filt_reg <= hist_reg[0];
            end
            prev_reg <= level;
        end
    end

    // falling when low, rising when high
    assign cap_event = edge_sel ? (level & ~prev_reg)
                                : (~level & prev_reg);
endmodule
`default_nettype wire

// [rtl/tmc_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Notes on behaviour
// - mode from ctrl B high, ctrl A low
// - mode 0 counts to ffff, flag at max
// - modes 1-3 dual slope, reload top
// - modes 5-7 fast, reload bottom, flag top
// - modes 4,12 clear on match, immediate
// - modes 8-11 dual slope, flag bottom
// - modes 14,15 fast; 13 reserved
// - clock select zero stops the counter
// - codes 1-5 divide by 1..1024
// - codes 6,7 external falling, rising edge
// - filter needs four equal samples
// - edge select: zero falling, one rising
// - capture copies counter, sets capture flag
// - capture off when capture sets top
// - force bit acts only in non-PWM modes
// - forced match: no flag, no clear
// - force bits are strobes, read zero
// - tick is a clock enable only
// - non-PWM actions: off, toggle, clear, set
module tmc_top
    import tmc_pkg::*;
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // register port
    input  wire logic [tmc_pkg::ADDR_W-1:0] addr,
    input  wire logic [tmc_pkg::DATA_W-1:0] wr_data,
    input  wire logic                      wr_en,
    input  wire logic                      rd_en,
    output logic      [tmc_pkg::DATA_W-1:0] rd_data,
    // pins
    input  wire logic                      ext_tick_pin,
    input  wire logic                      capture_pin,
    output logic                           compare_out_a_pin,
    output logic                           compare_out_a_oe,
    output logic                           compare_out_b_pin,
    output logic                           compare_out_b_oe,
    // flags
    output logic                           overflow_flag,
    output logic                           capture_flag,
    output logic                           match_a_flag,
    output logic                           match_b_flag
);
    // ==========================================================
    // registers
    logic [7:0]  ctrl_a_reg;
    logic [7:0]  ctrl_b_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic        up_reg;
    logic        up_next;
    logic [15:0] cap_reg;
    logic [15:0] cmpa_buf_reg;
    logic [15:0] cmpb_buf_reg;
    logic [15:0] cmpa_reg;
    logic [15:0] cmpb_reg;
    logic [7:0]  rd_data_reg;
    logic [7:0]  rd_mux;
    logic        oc_a_reg;
    logic        oc_b_reg;
    logic        oe_a_reg;
    logic        oe_b_reg;
    logic        ovf_reg;
    logic        cap_flag_reg;
    logic        ma_reg;
    logic        mb_reg;

    // ==========================================================
    // mode decode
    wire [3:0] wave_mode_sel = {ctrl_b_reg[B_WAVE_LSB +: 2],
                                ctrl_a_reg[A_WAVE_LSB +: 2]};
    wire [1:0] com_a = ctrl_a_reg[A_COMA_LSB +: 2];
    wire [1:0] com_b = ctrl_a_reg[A_COMB_LSB +: 2];
    wire [2:0] clk_sel = ctrl_b_reg[B_CSEL_LSB +: 3];
    wire       capture_filter_en = ctrl_b_reg[B_FILT_BIT];
    wire       capture_edge_sel  = ctrl_b_reg[B_EDGE_BIT];

    function automatic tmc_class_t wave_class(input logic [3:0] m);
        unique case (m)
            4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11:
                wave_class = TMC_DUAL;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15:
                wave_class = TMC_FAST;
            default: wave_class = TMC_NONPWM;
        endcase
    endfunction

    function automatic tmc_upd_t upd_point(input logic [3:0] m);
        unique case (m)
            4'd1, 4'd2, 4'd3, 4'd10, 4'd11: upd_point = TMC_UPD_TOP;
            4'd5, 4'd6, 4'd7, 4'd8, 4'd9, 4'd14, 4'd15:
                upd_point = TMC_UPD_BOT;
            default: upd_point = TMC_UPD_NOW;
        endcase
    endfunction

    // compare output action for one channel
    function automatic logic out_next(
        input logic [1:0] com, input logic cur, input logic hit,
        input logic bot, input logic up, input tmc_class_t cls,
        input logic tog_ok);
        logic r;
        r = cur;
        unique case (cls)
            TMC_NONPWM: if (hit) begin
                unique case (com)
                    2'b00: r = cur;
                    2'b01: r = ~cur;
                    2'b10: r = 1'b0;
                    2'b11: r = 1'b1;
                endcase
            end
            TMC_FAST: begin
                if (com[1] && bot) r = ~com[0];
                else if (com[1] && hit) r = com[0];
                else if (com == 2'b01 && hit && tog_ok) r = ~cur;
            end
            TMC_DUAL: begin
                if (com[1] && hit) r = up ? com[0] : ~com[0];
                else if (com == 2'b01 && hit && tog_ok) r = ~cur;
            end
            default: r = cur;
        endcase
        return r;
    endfunction

    tmc_class_t cls;
    tmc_upd_t   upd;
    logic [15:0] top_val;
    assign cls = wave_class(wave_mode_sel);
    assign upd = upd_point(wave_mode_sel);

    wire top_cap = (wave_mode_sel == 4'd8) || (wave_mode_sel == 4'd10)
                || (wave_mode_sel == 4'd12) || (wave_mode_sel == 4'd14);
    wire top_cmpa = (wave_mode_sel == 4'd4) || (wave_mode_sel == 4'd9)
                 || (wave_mode_sel == 4'd11) || (wave_mode_sel == 4'd15);

    always_comb begin
        unique case (wave_mode_sel)
            4'd1, 4'd5: top_val = TOP_8B;
            4'd2, 4'd6: top_val = TOP_9B;
            4'd3, 4'd7: top_val = TOP_10B;
            default: top_val = top_cap ? cap_reg
                             : (top_cmpa ? cmpa_reg : TOP_MAX);
        endcase
    end

    // ==========================================================
    // tick and capture sources
    logic timer_tick;
    logic cap_event;

    tmc_tick_gen u_tick (
        .clk          (clk),
        .rst_n        (rst_n),
        .clk_sel      (clk_sel),
        .ext_tick_pin (ext_tick_pin),
        .timer_tick   (timer_tick)
    );

    tmc_capture_filter #(.LEN(FILTER_LEN)) u_cap (
        .clk         (clk),
        .rst_n       (rst_n),
        .filter_en   (capture_filter_en),
        .edge_sel    (capture_edge_sel),
        .capture_pin (capture_pin),
        .cap_event   (cap_event)
    );

    // ==========================================================
    // counting
    wire at_top  = (cnt_reg == top_val);
    wire at_bot  = (cnt_reg == 16'h0000);
    wire dual    = (cls == TMC_DUAL);
    wire wrap_bt = timer_tick && (dual ? (at_bot && !up_reg) : at_top);
    wire ovf_set = timer_tick && ((cls == TMC_FAST) ? at_top
                 : dual ? (at_bot && !up_reg)
                 : (cnt_reg == TOP_MAX));
    wire reload  = (upd == TMC_UPD_NOW)
                || (upd == TMC_UPD_TOP && timer_tick && at_top)
                || (upd == TMC_UPD_BOT && wrap_bt);
    wire hit_a   = timer_tick && (cnt_reg == cmpa_reg);
    wire hit_b   = timer_tick && (cnt_reg == cmpb_reg);
    wire cap_fire = cap_event && !top_cap;

    always_comb begin
        cnt_next = cnt_reg;
        up_next  = up_reg;
        if (timer_tick) begin
            if (!dual) begin
                cnt_next = at_top ? 16'h0000 : cnt_reg + 16'h0001;
                up_next  = 1'b1;
            end else if (up_reg) begin
                cnt_next = at_top ? cnt_reg - 16'h0001
                                  : cnt_reg + 16'h0001;
                up_next  = !at_top;
            end else begin
                cnt_next = at_bot ? cnt_reg + 16'h0001
                                  : cnt_reg - 16'h0001;
                up_next  = at_bot;
            end
        end
        if (wr_en && addr == OFF_CNT_LO) cnt_next[7:0]  = wr_data;
        if (wr_en && addr == OFF_CNT_HI) cnt_next[15:8] = wr_data;
    end

    // ==========================================================
    // force strobes and waveform
    wire wr_c    = wr_en && (addr == OFF_CTRL_C);
    wire force_a = wr_c && wr_data[C_FORCE_A] && cls == TMC_NONPWM;
    wire force_b = wr_c && wr_data[C_FORCE_B] && cls == TMC_NONPWM;
    wire tog_a   = (wave_mode_sel == 4'd9) || (wave_mode_sel == 4'd11)
                || (wave_mode_sel == 4'd14) || (wave_mode_sel == 4'd15);
    wire bot_ev  = (cls == TMC_FAST) && wrap_bt;
    wire oc_a_next = out_next(com_a, oc_a_reg, hit_a || force_a, bot_ev,
                              up_reg, cls, tog_a);
    wire oc_b_next = out_next(com_b, oc_b_reg, hit_b || force_b, bot_ev,
                              up_reg, cls, 1'b0);
    wire oe_a_next = (com_a != 2'b00) &&
                     (cls == TMC_NONPWM || com_a[1] || tog_a);
    wire oe_b_next = (com_b != 2'b00) && (cls == TMC_NONPWM || com_b[1]);

    // ==========================================================
    // register port
    wire clr_st = wr_en && (addr == OFF_STATUS);

    always_comb begin
        unique case (addr)
            OFF_CTRL_A:  rd_mux = ctrl_a_reg;
            OFF_CTRL_B:  rd_mux = ctrl_b_reg;
            OFF_STATUS:  rd_mux = {2'b00, cap_flag_reg, 2'b00, mb_reg,
                                   ma_reg, ovf_reg};
            OFF_CNT_LO:  rd_mux = cnt_reg[7:0];
            OFF_CNT_HI:  rd_mux = cnt_reg[15:8];
            OFF_CAP_LO:  rd_mux = cap_reg[7:0];
            OFF_CAP_HI:  rd_mux = cap_reg[15:8];
            OFF_CMPA_LO: rd_mux = cmpa_buf_reg[7:0];
            OFF_CMPA_HI: rd_mux = cmpa_buf_reg[15:8];
            OFF_CMPB_LO: rd_mux = cmpb_buf_reg[7:0];
            OFF_CMPB_HI: rd_mux = cmpb_buf_reg[15:8];
            default:     rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_reg   <= CTRL_A_RST;
            ctrl_b_reg   <= CTRL_B_RST;
            cmpa_buf_reg <= '0;
            cmpb_buf_reg <= '0;
            rd_data_reg  <= '0;
        end else begin
            if (wr_en && addr == OFF_CTRL_A)
                ctrl_a_reg <= wr_data & CTRL_A_WMASK;
            if (wr_en && addr == OFF_CTRL_B)
                ctrl_b_reg <= wr_data & CTRL_B_WMASK;
            if (wr_en && addr == OFF_CMPA_LO) cmpa_buf_reg[7:0]  <= wr_data;
            if (wr_en && addr == OFF_CMPA_HI) cmpa_buf_reg[15:8] <= wr_data;
            if (wr_en && addr == OFF_CMPB_LO) cmpb_buf_reg[7:0]  <= wr_data;
            if (wr_en && addr == OFF_CMPB_HI) cmpb_buf_reg[15:8] <= wr_data;
            rd_data_reg <= rd_en ? rd_mux : 8'h00;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg  <= '0;
            up_reg   <= 1'b1;
            cmpa_reg <= '0;
            cmpb_reg <= '0;
            cap_reg  <= '0;
        end else begin
            cnt_reg <= cnt_next;
            up_reg  <= up_next;
            if (reload) begin
                cmpa_reg <= cmpa_buf_reg;
                cmpb_reg <= cmpb_buf_reg;
            end
            if (cap_fire) cap_reg <= cnt_reg;
            else if (wr_en && addr == OFF_CAP_LO) cap_reg[7:0] <= wr_data;
            else if (wr_en && addr == OFF_CAP_HI) cap_reg[15:8] <= wr_data;
        end
    end

    // flags: a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg      <= 1'b0;
            cap_flag_reg <= 1'b0;
            ma_reg       <= 1'b0;
            mb_reg       <= 1'b0;
            oc_a_reg     <= 1'b0;
            oc_b_reg     <= 1'b0;
            oe_a_reg     <= 1'b0;
            oe_b_reg     <= 1'b0;
        end else begin
            ovf_reg <= ovf_set || (ovf_reg && !(clr_st && wr_data[S_OVF_BIT]));
            cap_flag_reg <= cap_fire ||
                (cap_flag_reg && !(clr_st && wr_data[S_CAP_BIT]));
            ma_reg <= hit_a || (ma_reg && !(clr_st && wr_data[S_MA_BIT]));
            mb_reg <= hit_b || (mb_reg && !(clr_st && wr_data[S_MB_BIT]));
            oc_a_reg <= oc_a_next;
            oc_b_reg <= oc_b_next;
            oe_a_reg <= oe_a_next;
            oe_b_reg <= oe_b_next;
        end
    end

    assign rd_data           = rd_data_reg;
    assign compare_out_a_pin = oc_a_reg;
    assign compare_out_b_pin = oc_b_reg;
    assign compare_out_a_oe  = oe_a_reg;
    assign compare_out_b_oe  = oe_b_reg;
    assign overflow_flag     = ovf_reg;
    assign capture_flag      = cap_flag_reg;
    assign match_a_flag      = ma_reg;
    assign match_b_flag      = mb_reg;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence cap_seen;
        cap_event && !top_cap;
    endsequence
    sequence cap_stored;
        capture_flag && (cap_reg == $past(cnt_reg));
    endsequence

    stop_no_tick_a: assert property (clk_sel == 3'd0 |-> !timer_tick)
        else $error("tick while clock stopped");
    div1_tick_a: assert property (clk_sel == 3'd1 |-> timer_tick)
        else $error("no tick at divide by one");
    read_c_zero_a: assert property (rd_en && addr == OFF_CTRL_C
        |=> rd_data == 8'h00) else $error("force bits read nonzero");
    capture_copy_a: assert property (cap_seen |=> cap_stored)
        else $error("capture not stored");
    capture_off_a: assert property (top_cap && !(wr_en &&
        (addr == OFF_CAP_LO || addr == OFF_CAP_HI))
        |=> cap_reg == $past(cap_reg)) else $error("capture while top");
    force_no_flag_a: assert property (force_a && !timer_tick
        && !ma_reg |=> !ma_reg && cnt_reg == $past(cnt_reg))
        else $error("forced match set flag or cleared");
    force_toggle_a: assert property (force_a && !timer_tick
        && com_a == 2'b01 |=> compare_out_a_pin != $past(oc_a_reg))
        else $error("forced toggle missing");
    normal_wrap_a: assert property (timer_tick
        && wave_mode_sel == 4'd0 && cnt_reg == 16'hffff && !wr_en
        |=> cnt_reg == 16'h0000 && overflow_flag)
        else $error("normal wrap wrong");
    fast8_top_a: assert property (timer_tick && wave_mode_sel == 4'd5
        && cnt_reg == 16'h00ff && !wr_en |=> cnt_reg == 16'h0000
        && overflow_flag) else $error("fast 8-bit top wrong");
endmodule
`default_nettype wire

// [test/tmc_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: external count pin and capture pin
module tmc_pin_model (
    // clock
    input  wire logic clk,
    // pins
    output logic      ext_tick_pin,
    output logic      capture_pin
);
    initial begin
        ext_tick_pin = 1'b0;
        capture_pin  = 1'b0;
    end
    // slow pulses, well above the synchroniser depth
    task automatic ext_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            ext_tick_pin <= 1'b1;
            repeat (4) @(posedge clk);
            ext_tick_pin <= 1'b0;
        end
    endtask
    task automatic cap_level(input logic v, input int hold);
        @(posedge clk);
        capture_pin <= v;
        repeat (hold) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// [test/tmc_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_top_tb;
    import tmc_pkg::*;
    logic       clk, rst_n, wr_en, rd_en, ext_pin, cap_pin;
    logic       oa, oa_oe, ob, ob_oe, ovf, capf, maf, mbf;
    logic [7:0] addr, wr_data, rd_data, d;
    int         error_cnt, checked, seed, k, pin_exp;
    int         dv[5] = '{1, 8, 64, 256, 1024};
    int         md[4] = '{0, 5, 6, 7};
    int         tp[4] = '{'hffff, 'h00ff, 'h01ff, 'h03ff};
    int         act[$] = '{2, 1, 3, 1};

    tmc_top u_tmc_top (.clk(clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .ext_tick_pin(ext_pin), .capture_pin(cap_pin),
        .compare_out_a_pin(oa), .compare_out_a_oe(oa_oe),
        .compare_out_b_pin(ob), .compare_out_b_oe(ob_oe),
        .overflow_flag(ovf), .capture_flag(capf),
        .match_a_flag(maf), .match_b_flag(mbf));
    tmc_pin_model u_tmc_pin_model (.clk(clk), .ext_tick_pin(ext_pin),
        .capture_pin(cap_pin));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string n, input logic [7:0] s,
                         input logic [7:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr    <= a;
        wr_data <= v;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done;
    end
    initial begin
        seed = 85;
        rst_n = 1'b0;
        {addr, wr_data, wr_en, rd_en} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_CTRL_B);
        check("ctrl_b_rst", d, CTRL_B_RST);
        k = $random(seed);
        wr(OFF_CTRL_B, k[7:0]);
        rd(OFF_CTRL_B);
        check("ctrl_b", d, k[7:0] & CTRL_B_WMASK);
        wr(OFF_CTRL_C, 8'hc0);
        rd(OFF_CTRL_C);
        check("force_rd", d, 8'h00);
        // exactly four ticks in a window of four divider periods
        for (int i = 0; i < 5; i++) begin
            wr(OFF_CTRL_B, 8'h00);
            wr(OFF_CNT_LO, 8'h00);
            wr(OFF_CNT_HI, 8'h00);
            wr(OFF_CTRL_B, 8'(i + 1));
            cyc(4 * dv[i] - 2);
            wr(OFF_CTRL_B, 8'h00);
            rd(OFF_CNT_LO);
            check("div_cnt", d, 8'h04);
        end
        cyc(40);
        rd(OFF_CNT_LO);
        check("stopped", d, 8'h04);
        for (int i = 6; i < 8; i++) begin
            wr(OFF_CNT_LO, 8'h00);
            wr(OFF_CTRL_B, 8'(i));
            u_tmc_pin_model.ext_pulses(3);
            cyc(8);
            wr(OFF_CTRL_B, 8'h00);
            rd(OFF_CNT_LO);
            check("ext_cnt", d, 8'h03);
        end
        // overflow at the mode's top, then wrap
        for (int i = 0; i < 4; i++) begin
            wr(OFF_CTRL_A, 8'(md[i] & 3));
            wr(OFF_CNT_LO, 8'(tp[i] - 1));
            wr(OFF_CNT_HI, 8'((tp[i] - 1) >> 8));
            wr(OFF_STATUS, 8'hff);
            cyc(1);
            check("ovf_clr", ovf, 1'b0);
            wr(OFF_CTRL_B, 8'(((md[i] >> 2) << 3) | 1));
            cyc(6);
            check("ovf_top", ovf, 1'b1);
            wr(OFF_CTRL_B, 8'h00);
            rd(OFF_CNT_HI);
            check("wrap_hi", d, 8'h00);
        end
        // dual slope: turns at top, flags at bottom
        wr(OFF_CTRL_A, 8'h01);
        wr(OFF_CNT_LO, 8'hfe);
        wr(OFF_STATUS, 8'hff);
        wr(OFF_CTRL_B, 8'h01);
        cyc(6);
        check("dual_top", ovf, 1'b0);
        cyc(252);
        check("dual_bot", ovf, 1'b1);
        wr(OFF_CTRL_A, 8'h00);
        wr(OFF_CTRL_B, 8'h41);
        wr(OFF_STATUS, 8'hff);
        u_tmc_pin_model.cap_level(1'b1, 12);
        check("cap_rise", capf, 1'b1);
        wr(OFF_STATUS, 8'h20);
        u_tmc_pin_model.cap_level(1'b0, 12);
        check("cap_fall", capf, 1'b0);
        wr(OFF_CTRL_B, 8'hc1);
        u_tmc_pin_model.cap_level(1'b1, 2);
        u_tmc_pin_model.cap_level(1'b0, 12);
        check("cap_glitch", capf, 1'b0);
        u_tmc_pin_model.cap_level(1'b1, 12);
        check("cap_filt", capf, 1'b1);
        wr(OFF_CTRL_B, 8'h59);
        u_tmc_pin_model.cap_level(1'b0, 12);
        wr(OFF_STATUS, 8'hff);
        u_tmc_pin_model.cap_level(1'b1, 12);
        check("cap_off", capf, 1'b0);
        // clear on match, then forced matches in stopped clear-on-match mode
        wr(OFF_CTRL_B, 8'h08);
        wr(OFF_CMPA_LO, 8'h03);
        wr(OFF_CNT_LO, 8'h00);
        wr(OFF_CNT_HI, 8'h00);
        wr(OFF_STATUS, 8'hff);
        wr(OFF_CTRL_B, 8'h09);
        cyc(5);
        wr(OFF_CTRL_B, 8'h08);
        rd(OFF_CNT_LO);
        check("ctc_clear", d, 8'h03);
        check("ctc_match", {ovf, maf}, 2'b01);
        wr(OFF_CNT_LO, 8'h55);
        wr(OFF_STATUS, 8'hff);
        pin_exp = 0;
        foreach (act[i]) begin
            wr(OFF_CTRL_A, 8'((act[i] << 6) | (act[i] << 4)));
            wr(OFF_CTRL_C, 8'hc0);
            cyc(2);
            pin_exp = act[i] == 2 ? 0 : act[i] == 3 ? 1 : 1 - pin_exp;
            check("force_a", oa, 8'(pin_exp));
            check("force_b", ob, 8'(pin_exp));
            check("force_oe", oa_oe, 1'b1);
            check("force_oe_b", ob_oe, 1'b1);
        end
        check("force_flag", {maf, mbf}, 2'b00);
        rd(OFF_CNT_LO);
        check("force_cnt", d, 8'h55);
        wr(OFF_CTRL_A, 8'hc1);
        wr(OFF_CTRL_C, 8'h80);
        cyc(2);
        check("pwm_force", oa, 8'(pin_exp));
        test_done;
    end
endmodule
`default_nettype wire
